/* File: rtl/dpmm_pkg.sv */
// Purpose: Shared constants and types of the dual pointer data memory map.
// Assumes: Word-wide register bus, one register per aligned word.
// Notes:   Register indexes are word indexes; byte address is index times four.
package dpmm_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [9:0] AUX_CONTROL_ONE_INDEX = 10'h0A2;
  localparam logic [9:0] AUX_CONTROL_INDEX     = 10'h08E;
  localparam logic [9:0] POINTER_ACTIVE_INDEX  = 10'h000;
  localparam logic [9:0] POINTER_ZERO_INDEX    = 10'h001;
  localparam logic [9:0] POINTER_ONE_INDEX     = 10'h002;
  localparam logic [9:0] STATUS_INDEX          = 10'h003;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POINTER_SELECT_BIT  = 0;
  localparam int ZERO_BIT            = 2;
  localparam int USER_FLAG_BIT       = 3;
  localparam int BOOT_MAP_ENABLE_BIT = 5;
  localparam int ALE_ONLY_BIT        = 0;
  localparam int EXTERNAL_SELECT_BIT = 1;
  localparam int XMEM_SIZE_LO_BIT    = 2;
  localparam int XMEM_SIZE_HI_BIT    = 3;
  localparam int STROBE_STRETCH_BIT  = 5;
  localparam int PULLUP_OFF_BIT      = 7;

  // ----------------------------------------------------------------
  // Reset values, map limits and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  XMEM_SIZE_RESET      = 2'h0;
  localparam logic [15:0] BOOT_BASE            = 16'hF800;
  localparam logic [7:0]  LOWER_RAM_TOP        = 8'h7F;
  localparam int          EXPANDED_RAM_BYTES           = 1024;
  localparam int          IRAM_BYTES           = 256;
  localparam logic [4:0]  STROBE_SHORT_CYCLES  = 5'h06;
  localparam logic [4:0]  STROBE_LONG_CYCLES   = 5'h1E;
  localparam logic [1:0]  STRAP_SETTLE_CYCLES  = 2'h3;

  // Access kinds presented by the core.
  typedef enum logic [2:0] {
    KIND_DIRECT   = 3'b000,
    KIND_INDIRECT = 3'b001,
    KIND_STACK    = 3'b010,
    KIND_MOVX_RI  = 3'b011,
    KIND_MOVX_PTR = 3'b100
  } access_kind_type;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_MEM    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100
  } seq_state_type;
endpackage

/* File: rtl/dual_pointer_data_memory_map.sv */
// Purpose: Data memory steering with two data pointers, boot map and xdata bus.
// Assumes: One access request at a time from the core; registers over AHB-Lite.
// Notes:   Register file answers with no wait states; xdata strobes stretchable.
`timescale 1ns/1ps
`default_nettype none
module dual_pointer_data_memory_map
  import dpmm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        cpu_req,
  input  wire logic [2:0]  cpu_kind,
  input  wire logic        cpu_write,
  input  wire logic [7:0]  cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  output logic             cpu_busy,
  output logic             cpu_done,
  output logic [7:0]       cpu_rdata,
  output logic             sfr_req,
  output logic             sfr_write,
  output logic [7:0]       sfr_addr,
  output logic [7:0]       sfr_wdata,
  input  wire logic [15:0] code_addr,
  output logic             boot_hit,
  input  wire logic        security_ext_select,
  input  wire logic [7:0]  port0_in,
  output logic [7:0]       port0_out,
  output logic             port0_oe_n,
  output logic [7:0]       port2_out,
  output logic             port2_oe_n,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic             ale,
  output logic             ale_only_xdata,
  output logic             pullup_off
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          pointer_select;
    logic          user_flag;
    logic          boot_en;
    logic          ao;
    logic          ext_sel;
    logic [1:0]    xsize;
    logic          stretch;
    logic          dpu;
    logic [15:0]   ptr0;
    logic [15:0]   ptr1;
    logic          dph_wr;
    logic [9:0]    dph_idx;
    logic [31:0]   rd;
    seq_state_type st;
    logic [4:0]    cnt;
    logic          is_write;
    logic          mem_expanded_ram;
    logic [7:0]    p0_out;
    logic          p0_oe_n;
    logic [7:0]    p2_out;
    logic          p2_oe_n;
    logic          wr_n;
    logic          rd_n;
    logic          ale;
    logic [1:0]    strap_cnt;
    logic          strap_s1;
    logic          strap_s2;
    logic [7:0]    p0_s1;
    logic [7:0]    p0_s2;
    logic          done;
    logic [7:0]    rdata;
    logic          sfr_req;
    logic          sfr_write;
    logic [7:0]    sfr_addr;
    logic [7:0]    sfr_wdata;
    logic          boot_hit;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic [7:0] iram [IRAM_BYTES];
  logic [7:0] expanded_ram [EXPANDED_RAM_BYTES];
  logic [7:0] iram_rd_q;
  logic [7:0] expanded_ram_rd_q;

  logic        iram_we;
  logic [7:0]  iram_addr;
  logic        expanded_ram_we;
  logic [9:0]  expanded_ram_addr;
  logic [7:0]  mem_wdata;

  // True when an xdata address lies inside the enabled expanded RAM.
  function automatic logic expanded_ram_inside(input logic [15:0] a, input logic [1:0] sz);
    expanded_ram_inside = (a[15:10] == 6'h00) && (a[9:8] <= sz);
  endfunction

  // Reads of the mapped registers; reserved and unmapped bits read zero.
  function automatic logic [31:0] reg_read(input logic [9:0] idx, input state_type s);
    reg_read = 32'h0000_0000;
    case (idx)
      AUX_CONTROL_ONE_INDEX: begin
        reg_read[POINTER_SELECT_BIT]  = s.pointer_select;
        reg_read[USER_FLAG_BIT]       = s.user_flag;
        reg_read[BOOT_MAP_ENABLE_BIT] = s.boot_en;
        reg_read[ZERO_BIT]            = 1'b0;
      end
      AUX_CONTROL_INDEX: begin
        reg_read[ALE_ONLY_BIT]        = s.ao;
        reg_read[EXTERNAL_SELECT_BIT] = s.ext_sel;
        reg_read[XMEM_SIZE_LO_BIT]    = s.xsize[0];
        reg_read[XMEM_SIZE_HI_BIT]    = s.xsize[1];
        reg_read[STROBE_STRETCH_BIT]  = s.stretch;
        reg_read[PULLUP_OFF_BIT]      = s.dpu;
      end
      POINTER_ACTIVE_INDEX: reg_read[15:0] = s.pointer_select ? s.ptr1 : s.ptr0;
      POINTER_ZERO_INDEX:   reg_read[15:0] = s.ptr0;
      POINTER_ONE_INDEX:    reg_read[15:0] = s.ptr1;
      STATUS_INDEX:         reg_read[3:0]  = {s.st != ST_IDLE, s.st};
      default:              reg_read = 32'h0000_0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One process computes everything; the memories are kept apart because
  // a kilobyte inside the state struct would only bloat the copy.
  always_comb begin
    logic [15:0]     ptr;
    logic [15:0]     xaddr;
    logic            take;
    logic            wr_now;
    logic [4:0]      strobe_len;
    access_kind_type kind;
    s_d        = s_q;
    ptr        = s_q.pointer_select ? s_q.ptr1 : s_q.ptr0;
    kind       = access_kind_type'(cpu_kind);
    xaddr      = (kind == KIND_MOVX_PTR) ? ptr : {8'h00, cpu_addr};
    take       = cpu_req && (s_q.st == ST_IDLE);
    wr_now     = s_q.dph_wr;
    strobe_len = s_q.stretch ? STROBE_LONG_CYCLES : STROBE_SHORT_CYCLES;
    iram_we    = 1'b0;
    expanded_ram_we    = 1'b0;
    iram_addr  = cpu_addr;
    expanded_ram_addr  = xaddr[9:0];
    mem_wdata  = cpu_wdata;

    // Pin and strap synchronisers.
    s_d.p0_s1    = port0_in;
    s_d.p0_s2    = s_q.p0_s1;
    s_d.strap_s1 = security_ext_select;
    s_d.strap_s2 = s_q.strap_s1;

    // Load the external select from the security byte once it has settled.
    if (s_q.strap_cnt != STRAP_SETTLE_CYCLES) begin
      s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      if (s_q.strap_cnt == STRAP_SETTLE_CYCLES - 2'h1) begin
        s_d.ext_sel = s_q.strap_s2;
      end
    end

    // Boot memory decode of the code fetch address.
    s_d.boot_hit = s_q.boot_en && (code_addr >= BOOT_BASE);

    // Register bus: capture the address phase, answer in the data phase.
    s_d.dph_wr = hsel && hready && htrans[1] && hwrite;
    if (hsel && hready && htrans[1]) begin
      s_d.dph_idx = haddr[11:2];
      s_d.rd      = reg_read(haddr[11:2], s_q);
    end
    if (wr_now) begin
      case (s_q.dph_idx)
        AUX_CONTROL_ONE_INDEX: begin
          s_d.pointer_select       = hwdata[POINTER_SELECT_BIT];
          s_d.user_flag = hwdata[USER_FLAG_BIT];
          s_d.boot_en   = hwdata[BOOT_MAP_ENABLE_BIT];
        end
        AUX_CONTROL_INDEX: begin
          s_d.ao      = hwdata[ALE_ONLY_BIT];
          s_d.ext_sel = hwdata[EXTERNAL_SELECT_BIT];
          s_d.xsize   = {hwdata[XMEM_SIZE_HI_BIT], hwdata[XMEM_SIZE_LO_BIT]};
          s_d.stretch = hwdata[STROBE_STRETCH_BIT];
          s_d.dpu     = hwdata[PULLUP_OFF_BIT];
        end
        POINTER_ACTIVE_INDEX: begin
          if (s_q.pointer_select) begin
            s_d.ptr1 = hwdata[15:0];
          end else begin
            s_d.ptr0 = hwdata[15:0];
          end
        end
        POINTER_ZERO_INDEX: s_d.ptr0 = hwdata[15:0];
        POINTER_ONE_INDEX:  s_d.ptr1 = hwdata[15:0];
        default: begin
        end
      endcase
    end

    // One-cycle pulses fall back by default.
    s_d.done    = 1'b0;
    s_d.sfr_req = 1'b0;

    // Access sequencer.
    case (s_q.st)
      ST_IDLE: begin
        if (take) begin
          s_d.is_write = cpu_write;
          case (kind)
            KIND_DIRECT: begin
              if (cpu_addr > LOWER_RAM_TOP) begin
                s_d.sfr_req   = 1'b1;
                s_d.sfr_write = cpu_write;
                s_d.sfr_addr  = cpu_addr;
                s_d.sfr_wdata = cpu_wdata;
                s_d.done      = 1'b1;
                s_d.rdata     = 8'h00;
              end else begin
                iram_we      = cpu_write;
                s_d.mem_expanded_ram = 1'b0;
                s_d.st       = ST_MEM;
              end
            end
            KIND_INDIRECT, KIND_STACK: begin
              // Both halves of the 256-byte RAM, never the expanded RAM.
              iram_we      = cpu_write;
              s_d.mem_expanded_ram = 1'b0;
              s_d.st       = ST_MEM;
            end
            KIND_MOVX_RI, KIND_MOVX_PTR: begin
              if (!s_q.ext_sel && expanded_ram_inside(xaddr, s_q.xsize)) begin
                // Register-indirect moves never pass FFh: xaddr high byte is zero.
                expanded_ram_we      = cpu_write;
                s_d.mem_expanded_ram = 1'b1;
                s_d.st       = ST_MEM;
              end else if (s_q.ext_sel || kind == KIND_MOVX_PTR) begin
                s_d.p0_out  = xaddr[7:0];
                s_d.p0_oe_n = 1'b0;
                s_d.p2_out  = xaddr[15:8];
                s_d.p2_oe_n = (kind == KIND_MOVX_RI);
                s_d.ale     = 1'b1;
                s_d.st      = ST_ADDR;
              end else begin
                s_d.done  = 1'b1;
                s_d.rdata = 8'h00;
              end
            end
            default: begin
              s_d.done  = 1'b1;
              s_d.rdata = 8'h00;
            end
          endcase
        end
      end
      ST_MEM: begin
        s_d.done  = 1'b1;
        s_d.rdata = s_q.mem_expanded_ram ? expanded_ram_rd_q : iram_rd_q;
        s_d.st    = ST_IDLE;
      end
      ST_ADDR: begin
        // Address latched by the outside on the falling address strobe.
        s_d.ale = 1'b0;
        s_d.cnt = strobe_len;
        s_d.st  = ST_STROBE;
        if (s_q.is_write) begin
          s_d.p0_out = cpu_wdata;
          s_d.wr_n   = 1'b0;
        end else begin
          s_d.p0_oe_n = 1'b1;
          s_d.rd_n    = 1'b0;
        end
      end
      ST_STROBE: begin
        s_d.cnt = s_q.cnt - 5'h01;
        if (s_q.cnt == 5'h01) begin
          s_d.wr_n = 1'b1;
          s_d.rd_n = 1'b1;
          s_d.st   = ST_HOLD;
          if (!s_q.is_write) begin
            s_d.rdata = s_q.p0_s2;
          end
        end
      end
      ST_HOLD: begin
        s_d.p0_oe_n = 1'b1;
        s_d.p2_oe_n = 1'b1;
        s_d.done    = 1'b1;
        s_d.st      = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reserved and undefined bits are cleared anyway so simulation starts clean.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_q           <= '0;
      s_q.pointer_select       <= 1'b0;
      s_q.xsize     <= XMEM_SIZE_RESET;
      s_q.st        <= ST_IDLE;
      s_q.p0_oe_n   <= 1'b1;
      s_q.p2_oe_n   <= 1'b1;
      s_q.wr_n      <= 1'b1;
      s_q.rd_n      <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Memory arrays; read data is ready one cycle after the request.
  always_ff @(posedge sys_clk) begin
    if (iram_we) begin
      iram[iram_addr] <= mem_wdata;
    end
    if (expanded_ram_we) begin
      expanded_ram[expanded_ram_addr] <= mem_wdata;
    end
    iram_rd_q <= iram[iram_addr];
    expanded_ram_rd_q <= expanded_ram[expanded_ram_addr];
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output except the constant hreadyout and hresp and the decoded cpu_busy is a flip-flop of the state struct.
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = s_q.rd;
  assign cpu_busy       = (s_q.st != ST_IDLE);
  assign cpu_done       = s_q.done;
  assign cpu_rdata      = s_q.rdata;
  assign sfr_req        = s_q.sfr_req;
  assign sfr_write      = s_q.sfr_write;
  assign sfr_addr       = s_q.sfr_addr;
  assign sfr_wdata      = s_q.sfr_wdata;
  assign boot_hit       = s_q.boot_hit;
  assign port0_out      = s_q.p0_out;
  assign port0_oe_n     = s_q.p0_oe_n;
  assign port2_out      = s_q.p2_out;
  assign port2_oe_n     = s_q.p2_oe_n;
  assign write_strobe_n = s_q.wr_n;
  assign read_strobe_n  = s_q.rd_n;
  assign ale            = s_q.ale;
  assign ale_only_xdata = s_q.ao;
  assign pullup_off     = s_q.dpu;

endmodule
`default_nettype wire

/* File: verification/dpmm_asserts.sv */
// Purpose: Port-level checks of the dual pointer data memory map.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes:   Bound from the bench top file; sees only top-level ports.
`timescale 1ns/1ps
`default_nettype none
module dpmm_checker
  import dpmm_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        cpu_req,
  input wire logic        cpu_busy,
  input wire logic        cpu_done,
  input wire logic        sfr_req,
  input wire logic [7:0]  sfr_addr,
  input wire logic [15:0] code_addr,
  input wire logic        boot_hit,
  input wire logic        port0_oe_n,
  input wire logic        write_strobe_n,
  input wire logic        read_strobe_n,
  input wire logic        ale
);
  localparam int DONE_MAX = 33;
  logic [5:0] low_q;
  logic [5:0] low_d;
  // Counts strobe-low cycles; a pulse of any other length than the two legal ones fails.
  always_comb begin
    low_d = (write_strobe_n && read_strobe_n) ? 6'h00 : low_q + 6'h01;
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      low_q <= 6'h00;
    end else begin
      low_q <= low_d;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_strobe_len;
    $rose(write_strobe_n && read_strobe_n) |-> (low_q == 6'h06 || low_q == 6'h1E);
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe pulse has an illegal length");
  property p_one_strobe;
    !(!write_strobe_n && !read_strobe_n);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("read and write strobes low together");
  property p_ale_first;
    ($fell(read_strobe_n) || $fell(write_strobe_n)) |-> $past(ale);
  endproperty
  a_ale_first: assert property (p_ale_first)
    else $error("strobe not preceded by address latch pulse");
  property p_ale_short;
    ale |=> !ale;
  endproperty
  a_ale_short: assert property (p_ale_short)
    else $error("address latch pulse longer than one cycle");
  property p_addr_driven;
    ale |-> !port0_oe_n;
  endproperty
  a_addr_driven: assert property (p_addr_driven)
    else $error("low address not driven during latch pulse");
  property p_read_release;
    !read_strobe_n |-> port0_oe_n;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("port 0 driven during read strobe");
  property p_write_drive;
    !write_strobe_n |-> !port0_oe_n;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("port 0 released during write strobe");
  property p_quiet_idle;
    !cpu_busy |-> (write_strobe_n && read_strobe_n);
  endproperty
  a_quiet_idle: assert property (p_quiet_idle)
    else $error("strobe active with no access in progress");
  property p_done_bound;
    (cpu_req && !cpu_busy) |-> ##[1:DONE_MAX] cpu_done;
  endproperty
  a_done_bound: assert property (p_done_bound)
    else $error("access did not complete in time");
  property p_boot;
    boot_hit |-> ($past(code_addr) >= BOOT_BASE);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot map hit below its base");
  property p_sfr_high;
    sfr_req |-> sfr_addr[7];
  endproperty
  a_sfr_high: assert property (p_sfr_high)
    else $error("special register access below 80h");
  c_ext_read: cover property ($fell(read_strobe_n));
  c_ext_write: cover property ($fell(write_strobe_n));
  c_boot: cover property (boot_hit);
  c_sfr: cover property (sfr_req);
endmodule
`default_nettype wire

/* File: verification/dual_pointer_data_memory_map_tb_top.sv */
// Purpose: Self-checking bench of the dual pointer data memory map.
// Assumes: Registers reached over AHB-Lite with zero wait states.
// Notes:   Expected values come from the documented map, never from the block.
`timescale 1ns/1ps
`default_nettype none
module dual_pointer_data_memory_map_tb_top
  import dpmm_pkg::*;
;
  localparam logic [31:0] A_ACT  = {20'h0, POINTER_ACTIVE_INDEX, 2'b00};
  localparam logic [31:0] A_P0   = {20'h0, POINTER_ZERO_INDEX, 2'b00};
  localparam logic [31:0] A_P1   = {20'h0, POINTER_ONE_INDEX, 2'b00};
  localparam logic [31:0] A_AUX  = {20'h0, AUX_CONTROL_INDEX, 2'b00};
  localparam logic [31:0] A_AUX1 = {20'h0, AUX_CONTROL_ONE_INDEX, 2'b00};
  logic        sys_clk = 1'b0;
  logic        reset, hsel, hwrite, cpu_req, cpu_write, strap, slow_reply, sfr_hit;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cpu_kind;
  logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata, sfr_addr, port0_in, port0_out, port2_out;
  logic [7:0]  rv, a_lo, a_hi;
  logic [15:0] code_addr;
  logic        hreadyout, cpu_busy, cpu_done, sfr_req, boot_hit, pins, p2_on;
  logic        port0_oe_n, port2_oe_n, write_strobe_n, read_strobe_n, ale;
  int          failures = 0;
  int          n_checks = 0;
  int          ncyc, nlow;

  dual_pointer_data_memory_map dut (.sys_clk(sys_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
    .cpu_req(cpu_req), .cpu_kind(cpu_kind), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_busy(cpu_busy), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
    .sfr_req(sfr_req), .sfr_write(), .sfr_addr(sfr_addr), .sfr_wdata(),
    .code_addr(code_addr), .boot_hit(boot_hit), .security_ext_select(strap),
    .port0_in(port0_in), .port0_out(port0_out), .port0_oe_n(port0_oe_n),
    .port2_out(port2_out), .port2_oe_n(port2_oe_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .ale(ale), .ale_only_xdata(), .pullup_off());
  ext_mem_model u_mem (.sys_clk(sys_clk), .ale(ale), .port0_out(port0_out),
    .port2_out(port2_out), .port2_oe_n(port2_oe_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .slow_reply(slow_reply), .port0_in(port0_in));

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      print_verdict();
    end
  endtask
  // One single-word transfer; read data is taken at the edge that ends the data phase.
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'b010;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic xfer(input logic [2:0] k, input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    cpu_req <= 1'b1;
    cpu_kind <= k;
    cpu_write <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    sfr_hit = 1'b0;
    @(posedge sys_clk);
    cpu_req <= 1'b0;
    ncyc = 0;
    nlow = 0;
    pins = 1'b0;
    p2_on = 1'b0;
    // Sampling starts just after the take edge, so the one-cycle address strobe is seen.
    do begin
      #1;
      ncyc++;
      sfr_hit = sfr_hit | (sfr_req === 1'b1);
      nlow += int'(!read_strobe_n || !write_strobe_n);
      if (ale) begin
        a_lo = port0_out;
        a_hi = port2_out;
        p2_on = !port2_oe_n;
      end
      pins = pins | ale | !port0_oe_n | !read_strobe_n | !write_strobe_n;
      if (cpu_done !== 1'b1) begin
        @(posedge sys_clk);
      end
    end while (cpu_done !== 1'b1 && ncyc < 60);
    rv = cpu_rdata;
    if (ncyc >= 60) begin
      failures++;
      print_verdict();
    end
    @(posedge sys_clk);
  endtask
  task automatic ptr(input logic [15:0] p, input logic w, input logic [7:0] d);
    ahb(1'b1, A_P0, {16'h0, p});
    xfer(KIND_MOVX_PTR, w, 8'h00, d);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset(input logic s);
    strap <= s;
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ahb(1'b0, A_AUX1, 32'h0);
    chk(rd & 32'h5, 32'h0);
    ahb(1'b0, A_AUX, 32'h0);
    chk(rd & 32'hE, {30'h0, s, 1'b0});
    ahb(1'b0, 32'h0000_0100, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_aux1();
    ahb(1'b1, A_AUX1, 32'h2C);
    ahb(1'b0, A_AUX1, 32'h0);
    chk(rd & 32'h2D, 32'h28);
    ahb(1'b1, A_AUX1, (rd & 32'h2D) + 32'h1);
    ahb(1'b0, A_AUX1, 32'h0);
    chk(rd & 32'h2D, 32'h29);
    code_addr <= 16'hF7FF;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, boot_hit}, 32'h0);
    code_addr <= 16'hF800;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, boot_hit}, 32'h1);
    ahb(1'b1, A_AUX1, 32'h09);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, boot_hit}, 32'h0);
  endtask
  task automatic t_pointers();
    ahb(1'b1, A_P0, 32'h1234);
    ahb(1'b1, A_P1, 32'hABCD);
    ahb(1'b0, A_ACT, 32'h0);
    chk(rd, 32'hABCD);
    ahb(1'b1, A_AUX, 32'h02);
    xfer(KIND_MOVX_PTR, 1'b1, 8'h00, 8'h5A);
    chk({16'h0, a_hi, a_lo}, 32'hABCD);
    chk({31'h0, p2_on}, 32'h1);
    chk(32'(ncyc * 100 + nlow), 32'd906);
    chk({24'h0, u_mem.mem[16'hABCD]}, 32'h5A);
    ahb(1'b1, A_AUX1, 32'h08);
    xfer(KIND_MOVX_PTR, 1'b1, 8'h00, 8'hC3);
    chk({16'h0, a_hi, a_lo}, 32'h1234);
    ahb(1'b1, A_AUX, 32'h22);
    ahb(1'b1, A_AUX1, 32'h09);
    slow_reply <= 1'b1;
    xfer(KIND_MOVX_PTR, 1'b0, 8'h00, 8'h00);
    chk(32'(ncyc * 100 + nlow), 32'd3330);
    chk({24'h0, rv}, 32'h5A);
    slow_reply <= 1'b0;
    ahb(1'b1, A_AUX, 32'h02);
    xfer(KIND_MOVX_RI, 1'b1, 8'h77, 8'h3C);
    chk({23'h0, p2_on, a_lo}, 32'h77);
    chk({24'h0, u_mem.mem[16'hFF77]}, 32'h3C);
  endtask
  task automatic t_expanded_ram();
    ahb(1'b1, A_AUX, 32'h00);
    ahb(1'b1, A_AUX1, 32'h00);
    ptr(16'h00C0, 1'b1, 8'h11);
    chk({31'h0, pins}, 32'h0);
    xfer(KIND_MOVX_RI, 1'b0, 8'hC0, 8'h00);
    chk({23'h0, pins, rv}, 32'h11);
    ptr(16'h0150, 1'b1, 8'h44);
    chk({23'h0, pins, u_mem.mem[16'h0150]}, 32'h144);
    ahb(1'b1, A_AUX, 32'h04);
    ptr(16'h01FF, 1'b1, 8'h55);
    chk({31'h0, pins}, 32'h0);
    ahb(1'b1, A_AUX, 32'h0C);
    ptr(16'h03FF, 1'b1, 8'h66);
    chk({31'h0, pins}, 32'h0);
    ptr(16'h0400, 1'b1, 8'h77);
    chk({23'h0, pins, u_mem.mem[16'h0400]}, 32'h177);
  endtask
  task automatic t_iram();
    xfer(KIND_DIRECT, 1'b1, 8'h30, 8'hA1);
    xfer(KIND_INDIRECT, 1'b0, 8'h30, 8'h00);
    chk({24'h0, rv}, 32'hA1);
    xfer(KIND_INDIRECT, 1'b1, 8'h90, 8'hB2);
    chk({31'h0, sfr_hit}, 32'h0);
    xfer(KIND_DIRECT, 1'b0, 8'h90, 8'h00);
    chk({31'h0, sfr_hit}, 32'h1);
    xfer(KIND_INDIRECT, 1'b0, 8'h90, 8'h00);
    chk({24'h0, rv}, 32'hB2);
    xfer(KIND_STACK, 1'b1, 8'hC0, 8'h22);
    xfer(KIND_INDIRECT, 1'b0, 8'hC0, 8'h00);
    chk({24'h0, rv}, 32'h22);
    xfer(KIND_MOVX_RI, 1'b0, 8'hC0, 8'h00);
    chk({24'h0, rv}, 32'h11);
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    cpu_req = 1'b0;
    cpu_write = 1'b0;
    cpu_kind = 3'h0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    code_addr = 16'h0000;
    strap = 1'b0;
    slow_reply = 1'b0;
    sfr_hit = 1'b0;
    t_reset(1'b0);
    t_aux1();
    t_pointers();
    t_expanded_ram();
    t_iram();
    t_reset(1'b1);
    print_verdict();
  end
endmodule

bind dual_pointer_data_memory_map dpmm_checker u_chk (.sys_clk(sys_clk), .reset(reset),
  .cpu_req(cpu_req), .cpu_busy(cpu_busy), .cpu_done(cpu_done), .sfr_req(sfr_req),
  .sfr_addr(sfr_addr), .code_addr(code_addr), .boot_hit(boot_hit),
  .port0_oe_n(port0_oe_n), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .ale(ale));
`default_nettype wire

/* File: verification/ext_mem_model.sv */
// Purpose: External byte memory on the multiplexed address and data bus.
// Assumes: Address latched while ale is high; data given while read strobe is low.
// Notes:   A released upper byte reads as all ones, as pulled-up pins would.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  input  wire logic       sys_clk,
  input  wire logic       ale,
  input  wire logic [7:0] port0_out,
  input  wire logic [7:0] port2_out,
  input  wire logic       port2_oe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       slow_reply,
  output logic      [7:0] port0_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_q = 16'h0000;
  int          low_n  = 0;
  initial port0_in = 8'h00;
  // A slow part shows garbage for 20 cycles; the released bus keeps toggling.
  always @(posedge sys_clk) begin
    if (ale) begin
      addr_q <= {port2_oe_n ? 8'hFF : port2_out, port0_out};
    end
    low_n <= read_strobe_n ? 0 : low_n + 1;
    if (!write_strobe_n) begin
      mem[addr_q] <= port0_out;
    end
    if (!read_strobe_n && low_n >= (slow_reply ? 20 : 0)) begin
      port0_in <= mem[addr_q];
    end else begin
      port0_in <= ~port0_in;
    end
  end
endmodule
`default_nettype wire
